/* File: hw/sre_target.sv */
// EEPROM end: address counter and read sequencing on the two-wire link.
// Array is outside; it answers mem_addr_o combinationally on mem_data_i.
//
// What this block and the host controller do
// [R1] Eighth address bit one selects read
// [R2] Counter holds last accessed address plus one
// [R3] Acknowledge address, then shift out addressed byte
// [R4] Counter steps after every byte sent
// [R5] Host ends single read with no-ack, STOP
// [R6] Host acknowledge requests next byte
// [R7] Bytes continue while host keeps acknowledging
// [R8] Counter wraps from top to first address
// [R9] Host ends sequential read with no-ack, STOP
// [R10] Dummy write loads counter from address bytes
// [R11] New START after dummy write reads there
// [R12] Host keeps SCL at or below 400 kHz
// [R13] Respond only to class code and selects
// [R14] START and STOP seen while SCL high
// [R15] Acknowledge each received byte on ninth clock
// [R16] Word address is thirteen bits, two bytes
// [R17] After host no-ack, stay silent until START/STOP
`timescale 1ns/10ps
module sre_target (
  input  wire logic                   clk_i,
  input  wire logic                   rst_i,
  input  wire logic                   chip_select_bit2_i,
  input  wire logic                   chip_select_bit1_i,
  input  wire logic                   chip_select_bit0_i,
  input  wire logic [7:0]             mem_data_i,
  output logic      [sre_pkg::ADDR_W-1:0] mem_addr_o,
  output logic                        wr_en_o,
  output logic      [7:0]             wr_data_o,
  output logic                        read_active_o,
  sre_link_if.dev                     link
);
  import sre_pkg::*;

  typedef enum logic [2:0] {
    T_IDLE, T_RECV, T_ACK, T_SEND, T_MACK, T_WAIT
  } sre_tgt_state_e;

  typedef enum logic [1:0] {RX_DEV, RX_AHI, RX_ALO, RX_DATA} sre_rx_e;

  // ************************************************************
  // Pin synchronisers and line events
  // ************************************************************
  logic [4:0]         sync_a;
  logic [4:0]         sync_b;
  logic [1:0]         line_prev;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sync_a    <= 5'h03;
      sync_b    <= 5'h03;
      line_prev <= 2'h3;
    end else begin
      sync_a    <= {chip_select_bit2_i, chip_select_bit1_i, chip_select_bit0_i,
                    link.scl, link.sda};
      sync_b    <= sync_a;
      line_prev <= sync_b[1:0];
    end
  end

  wire       scl_s      = sync_b[1];
  wire       sda_s      = sync_b[0];
  wire [2:0] chip_sel   = sync_b[4:2];
  wire       scl_p      = line_prev[1];
  wire       sda_p      = line_prev[0];
  wire       scl_rise   = scl_s && !scl_p;
  wire       scl_fall   = !scl_s && scl_p;
  wire       start_det  = scl_s && scl_p && sda_p && !sda_s;  // [R14]
  wire       stop_det   = scl_s && scl_p && !sda_p && sda_s;  // [R14]

  // ************************************************************
  // Byte engine state
  // ************************************************************
  sre_tgt_state_e     state;
  sre_rx_e            rx_kind;
  logic [3:0]         bit_cnt;
  logic [7:0]         shift;
  logic [4:0]         addr_hi;
  logic [ADDR_W-1:0]  addr_cnt;
  logic               read_mode;
  logic               host_ack;
  logic               sda_oe;

  // ************************************************************
  // Decode of the received byte and counter step
  // ************************************************************
  wire               byte_in_done = scl_fall && (bit_cnt == BIT_ACK);
  wire               class_ok     = (shift[7:4] == DEV_CLASS);           // [R13]
  wire               sel_ok       = (shift[3:1] == chip_sel);            // [R13]
  wire               dev_match    = class_ok && sel_ok;
  wire               is_read      = (shift[0] == RW_READ);               // [R1]
  wire [ADDR_W-1:0]  next_addr    = (addr_cnt == ADDR_LAST) ? ADDR_FIRST // [R8]
                                  : ADDR_W'(addr_cnt + 1'b1);
  wire [ADDR_W-1:0]  loaded_addr  = {addr_hi, shift};                    // [R16]
  wire               byte_ack     = (rx_kind != RX_DEV) || dev_match;
  wire [7:0]         load_next    = {mem_data_i[6:0], 1'b0};
  wire               load_first   = !mem_data_i[7];

  sre_rx_e next_rx_kind;
  always_comb begin
    case (rx_kind)
      RX_DEV:  next_rx_kind = RX_AHI;
      RX_AHI:  next_rx_kind = RX_ALO;
      default: next_rx_kind = RX_DATA;
    endcase
  end

  // ************************************************************
  // Sequencer
  // ************************************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state     <= T_IDLE;
      rx_kind   <= RX_DEV;
      bit_cnt   <= BIT_FIRST;
      shift     <= 8'h00;
      addr_hi   <= 5'h00;
      addr_cnt  <= ADDR_FIRST;
      read_mode <= 1'b0;
      host_ack  <= 1'b0;
      sda_oe    <= 1'b0;
      wr_en_o   <= 1'b0;
      wr_data_o <= 8'h00;
    end else begin
      wr_en_o <= 1'b0;
      if (start_det) begin
        // Repeated START drops any pending write and restarts decode
        state   <= T_RECV;                                         // [R11]
        rx_kind <= RX_DEV;
        bit_cnt <= BIT_FIRST;
        sda_oe  <= 1'b0;
      end else if (stop_det) begin
        state  <= T_IDLE;                                          // [R5]
        sda_oe <= 1'b0;
      end else begin
        case (state)
          T_RECV: begin
            if (scl_rise && (bit_cnt != BIT_ACK)) begin
              shift   <= {shift[6:0], sda_s};
              bit_cnt <= 4'(bit_cnt + 1'b1);
            end else if (byte_in_done) begin
              rx_kind <= next_rx_kind;
              case (rx_kind)
                RX_DEV:  read_mode <= is_read;                     // [R1]
                RX_AHI:  addr_hi   <= shift[4:0];                  // [R16]
                RX_ALO:  addr_cnt  <= loaded_addr;                 // [R10]
                default: begin
                  addr_cnt  <= next_addr;                          // [R2]
                  wr_en_o   <= 1'b1;
                  wr_data_o <= shift;
                end
              endcase
              if (byte_ack) begin
                sda_oe <= 1'b1;                                    // [R15]
                state  <= T_ACK;
              end else begin
                state <= T_WAIT;                                   // [R13]
              end
            end
          end
          T_ACK: begin
            if (scl_fall) begin
              if (read_mode) begin
                shift   <= load_next;                              // [R3]
                sda_oe  <= load_first;
                bit_cnt <= 4'h1;
                state   <= T_SEND;
              end else begin
                sda_oe  <= 1'b0;
                bit_cnt <= BIT_FIRST;
                state   <= T_RECV;
              end
            end
          end
          T_SEND: begin
            if (scl_fall) begin
              if (bit_cnt == BIT_ACK) begin
                sda_oe   <= 1'b0;
                addr_cnt <= next_addr;                             // [R4]
                state    <= T_MACK;
              end else begin
                sda_oe  <= !shift[7];
                shift   <= {shift[6:0], 1'b0};
                bit_cnt <= 4'(bit_cnt + 1'b1);
              end
            end
          end
          T_MACK: begin
            if (scl_rise) begin
              host_ack <= (sda_s == BUS_ACK);
            end else if (scl_fall) begin
              if (host_ack) begin
                shift   <= load_next;                              // [R6] [R7]
                sda_oe  <= load_first;
                bit_cnt <= 4'h1;
                state   <= T_SEND;
              end else begin
                state <= T_WAIT;                                   // [R17]
              end
            end
          end
          T_WAIT: begin
            sda_oe <= 1'b0;                                        // [R17]
          end
          default: begin
            sda_oe <= 1'b0;
          end
        endcase
      end
    end
  end

  // ************************************************************
  // Outputs
  // ************************************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      read_active_o <= 1'b0;
    end else begin
      read_active_o <= (state == T_SEND) || (state == T_MACK);
    end
  end

  assign mem_addr_o      = addr_cnt;
  assign link.dev_sda_oe = sda_oe;
  assign link.dev_sda_o  = 1'b0;

endmodule

/* File: hw/sre_pkg.sv */
// Shared constants and types for the two-wire EEPROM read path.
// Assumes a single 20 MHz clock on both ends of the link.
package sre_pkg;

  // ************************************************************
  // Array and addressing
  // ************************************************************
  localparam int unsigned     ADDR_W     = 13;
  localparam logic [12:0]     ADDR_FIRST = 13'h0000;
  localparam logic [12:0]     ADDR_LAST  = 13'h1fff;
  localparam logic [3:0]      DEV_CLASS  = 4'ha;
  localparam logic            RW_READ    = 1'b1;
  localparam logic            RW_WRITE   = 1'b0;
  localparam logic            BUS_ACK    = 1'b0;
  localparam logic            BUS_NACK   = 1'b1;
  localparam logic [3:0]      BIT_FIRST  = 4'h0;
  localparam logic [3:0]      BIT_DATA   = 4'h7;
  localparam logic [3:0]      BIT_ACK    = 4'h8;
  localparam logic [2:0]      HI_PAD     = 3'h0;
  localparam logic [7:0]      LEN_ONE    = 8'h01;

  // ************************************************************
  // Timing
  // ************************************************************
  localparam int unsigned     CLK_PERIOD_NS = 50;
  localparam int unsigned     SCL_MAX_KHZ   = 400;
  localparam int unsigned     SCL_PERIOD_NS = 1000000 / SCL_MAX_KHZ;
  localparam int unsigned     QTR_CYCLES    =
    (SCL_PERIOD_NS + 4 * CLK_PERIOD_NS - 1) / (4 * CLK_PERIOD_NS);
  localparam logic [3:0]      QTR_LAST      = 4'(QTR_CYCLES - 1);

  typedef enum logic {SRE_CMD_CURRENT, SRE_CMD_RANDOM} sre_cmd_e;

endpackage

/* File: hw/sre_link_if.sv */
// Two-wire link between the EEPROM end and the bus controller end.
// Both lines are open drain with a pull-up; enable high pulls low.
`timescale 1ns/10ps
interface sre_link_if;
  logic dev_sda_o;
  logic dev_sda_oe;
  logic host_sda_o;
  logic host_sda_oe;
  logic host_scl_o;
  logic host_scl_oe;
  logic scl;
  logic sda;

  // ************************************************************
  // Wired-AND resolution of the pulled-up lines
  // ************************************************************
  assign sda = !((dev_sda_oe && !dev_sda_o) || (host_sda_oe && !host_sda_o));
  assign scl = !(host_scl_oe && !host_scl_o);

  modport dev  (input scl, input sda, output dev_sda_o, output dev_sda_oe);
  modport host (input sda, output host_scl_o, output host_scl_oe,
                output host_sda_o, output host_sda_oe);
endinterface

/* File: hw/sre_controller.sv */
// Bus controller end: runs current-address and random reads of n bytes.
// Drives SCL from a divider of clk_i; the target never stretches SCL.
`timescale 1ns/10ps
module sre_controller (
  input  wire logic                   clk_i,
  input  wire logic                   rst_i,
  input  wire logic                   cmd_valid_i,
  input  wire sre_pkg::sre_cmd_e      cmd_kind_i,
  input  wire logic [sre_pkg::ADDR_W-1:0] cmd_addr_i,
  input  wire logic [2:0]             cmd_sel_i,
  input  wire logic [7:0]             cmd_len_i,
  output logic                        cmd_ready_o,
  output logic                        rd_valid_o,
  output logic      [7:0]             rd_data_o,
  output logic                        done_o,
  output logic                        nack_o,
  sre_link_if.host                    link
);
  import sre_pkg::*;

  typedef enum logic [2:0] {H_IDLE, H_START, H_SEND, H_RECV, H_STOP} sre_host_state_e;

  // ************************************************************
  // SDA synchroniser and quarter-bit divider
  // ************************************************************
  logic               sda_a;
  logic               sda_s;
  logic [3:0]         qdiv;
  logic [1:0]         q;
  sre_host_state_e    state;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sda_a <= 1'b1;
      sda_s <= 1'b1;
    end else begin
      sda_a <= link.sda;
      sda_s <= sda_a;
    end
  end

  wire qtick = (state != H_IDLE) && (qdiv == QTR_LAST);            // [R12]

  always_ff @(posedge clk_i) begin
    if (rst_i || (state == H_IDLE) || qtick) begin
      qdiv <= 4'h0;
    end else begin
      qdiv <= 4'(qdiv + 1'b1);
    end
  end

  // ************************************************************
  // Line patterns per quarter
  // ************************************************************
  logic [3:0]         bit_cnt;
  logic [7:0]         tx;
  logic [7:0]         rx;
  logic [1:0]         step;
  logic               wr_phase;
  logic [ADDR_W-1:0]  addr;
  logic [2:0]         sel;
  logic [7:0]         remaining;
  logic               scl_oe;
  logic               sda_oe;

  wire last_byte = (remaining == LEN_ONE);
  wire ack_bit   = (bit_cnt == BIT_ACK);
  wire send_val  = ack_bit ? 1'b1 : tx[7];
  wire recv_val  = ack_bit ? (last_byte ? BUS_NACK : BUS_ACK) : 1'b1;  // [R6] [R9]
  wire bit_val   = (state == H_SEND) ? send_val : recv_val;
  wire scl_pat   = (q == 2'h1) || (q == 2'h2) || ((state == H_STOP) && (q == 2'h3));
  wire sda_pat   = (state == H_START) ? (q < 2'h2)
                 : (state == H_STOP)  ? (q >= 2'h2) : bit_val;
  wire elem_end  = qtick && (q == 2'h3);
  wire dev_rw    = wr_phase ? RW_WRITE : RW_READ;                  // [R1] [R10]
  wire [7:0] dev_byte  = {DEV_CLASS, sel, dev_rw};
  wire [7:0] addr_byte = (step == 2'h0) ? {HI_PAD, addr[12:8]} : addr[7:0];  // [R16]

  // ************************************************************
  // Sequencer
  // ************************************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state       <= H_IDLE;
      q           <= 2'h0;
      bit_cnt     <= BIT_FIRST;
      tx          <= 8'h00;
      rx          <= 8'h00;
      step        <= 2'h0;
      wr_phase    <= 1'b0;
      addr        <= ADDR_FIRST;
      sel         <= 3'h0;
      remaining   <= LEN_ONE;
      scl_oe      <= 1'b0;
      sda_oe      <= 1'b0;
      cmd_ready_o <= 1'b1;
      rd_valid_o  <= 1'b0;
      rd_data_o   <= 8'h00;
      done_o      <= 1'b0;
      nack_o      <= 1'b0;
    end else begin
      rd_valid_o <= 1'b0;
      done_o     <= 1'b0;
      nack_o     <= 1'b0;
      if ((state == H_IDLE) && cmd_valid_i) begin
        state       <= H_START;
        q           <= 2'h0;
        step        <= 2'h0;
        wr_phase    <= (cmd_kind_i == SRE_CMD_RANDOM);             // [R10]
        addr        <= cmd_addr_i;
        sel         <= cmd_sel_i;
        remaining   <= (cmd_len_i == 8'h00) ? LEN_ONE : cmd_len_i;
        cmd_ready_o <= 1'b0;
      end else if (qtick) begin
        scl_oe <= !scl_pat;
        sda_oe <= !sda_pat;
        q      <= 2'(q + 1'b1);
        if (q == 2'h2) begin
          rx <= {rx[6:0], sda_s};
        end
      end
      if (elem_end) begin
        case (state)
          H_START: begin
            tx      <= dev_byte;
            bit_cnt <= BIT_FIRST;
            state   <= H_SEND;
          end
          H_SEND: begin
            if (!ack_bit) begin
              tx      <= {tx[6:0], 1'b0};
              bit_cnt <= 4'(bit_cnt + 1'b1);
            end else if (rx[0] == BUS_NACK) begin
              nack_o <= 1'b1;
              state  <= H_STOP;
            end else if (wr_phase && (step == 2'h2)) begin
              wr_phase <= 1'b0;                                    // [R11]
              state    <= H_START;
            end else if (wr_phase) begin
              tx      <= addr_byte;
              step    <= 2'(step + 1'b1);
              bit_cnt <= BIT_FIRST;
            end else begin
              bit_cnt <= BIT_FIRST;
              state   <= H_RECV;
            end
          end
          H_RECV: begin
            if (bit_cnt == BIT_DATA) begin
              rd_valid_o <= 1'b1;
              rd_data_o  <= rx;
            end
            if (!ack_bit) begin
              bit_cnt <= 4'(bit_cnt + 1'b1);
            end else if (last_byte) begin
              state <= H_STOP;                                     // [R5] [R9]
            end else begin
              remaining <= 8'(remaining - 1'b1);
              bit_cnt   <= BIT_FIRST;
            end
          end
          H_STOP: begin
            state       <= H_IDLE;
            done_o      <= 1'b1;
            cmd_ready_o <= 1'b1;
          end
          default: begin
            state <= H_IDLE;
          end
        endcase
      end
    end
  end

  assign link.host_scl_oe = scl_oe;
  assign link.host_sda_oe = sda_oe;
  assign link.host_scl_o  = 1'b0;
  assign link.host_sda_o  = 1'b0;

endmodule

/* File: tb/sre_link_monitor.sv */
// Concurrent checks on the two-wire link between target and controller.
// Assumes one clock domain and the target strapped to SEL_VAL.
`timescale 1ns/10ps
module sre_link_monitor
  import sre_pkg::*;
#(
  parameter logic [2:0] SEL_VAL = 3'h0
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic dev_sda_o,
  input wire logic dev_sda_oe,
  input wire logic host_sda_o,
  input wire logic host_sda_oe,
  input wire logic host_scl_o,
  input wire logic host_scl_oe,
  input wire logic scl,
  input wire logic sda
);
  // ************************************************************
  // Frame tracking
  // ************************************************************
  logic       scl_d;
  logic       sda_d;
  logic       rd;
  logic       quiet;
  logic [3:0] bc;
  logic [1:0] bi;
  logic [7:0] sh;
  logic [5:0] per_cnt;
  wire        rise  = scl && !scl_d;
  wire        start = scl && scl_d && sda_d && !sda;
  wire        stop  = scl && scl_d && !sda_d && sda;
  wire        ninth = rise && (bc == BIT_ACK);
  wire        match = sh[7:1] == {DEV_CLASS, SEL_VAL};
  wire        drop  = ninth && ((bi == 2'h0 && !match) || (bi != 2'h0 && rd && sda));

  always_ff @(posedge clk_i) begin
    scl_d <= rst_i | scl;
    sda_d <= rst_i | sda;
    per_cnt <= rst_i ? 6'h3f : (rise ? 6'h00 : per_cnt + {5'h00, per_cnt != 6'h3f});
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || start || stop) begin
      bc <= 4'h0;
      bi <= 2'h0;
      quiet <= 1'b0;
    end else if (rise) begin
      sh <= ninth ? sh : {sh[6:0], sda};
      bc <= ninth ? 4'h0 : bc + 4'h1;
      bi <= (ninth && bi != 2'h3) ? bi + 2'h1 : bi;
      rd <= (ninth && bi == 2'h0) ? sh[0] : rd;
      quiet <= quiet | drop;
    end
  end

  // ************************************************************
  // Properties
  // ************************************************************
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_stop;
    stop;
  endsequence
  sequence s_release;
    !dev_sda_oe [*8];
  endsequence

  property p_addr_ack;
    ninth && bi == 2'h0 |-> dev_sda_oe == match;
  endproperty
  property p_write_ack;
    ninth && bi != 2'h0 && !rd && !quiet |-> dev_sda_oe;
  endproperty
  property p_host_slot;
    ninth && bi != 2'h0 && rd |-> !dev_sda_oe;
  endproperty
  property p_quiet;
    quiet |-> !dev_sda_oe;
  endproperty
  property p_stop_quiet;
    s_stop |-> s_release;
  endproperty
  property p_stable_high;
    scl && $past(scl) |-> $stable(dev_sda_oe);
  endproperty
  property p_lag;
    $changed(dev_sda_oe) |-> !scl && !$past(scl, 2) &&
      ($past(scl, 3) || $past(scl, 4) || $past(scl, 5));
  endproperty
  property p_scl_rate;
    rise |-> per_cnt >= 6'h31;
  endproperty

  a_addr_ack: assert property (p_addr_ack) else $error("address acknowledge wrong");
  a_write_ack: assert property (p_write_ack) else $error("address byte not acked");
  a_host_slot: assert property (p_host_slot) else $error("target pulled in host slot");
  a_quiet: assert property (p_quiet) else $error("target drove while silent");
  a_stop_quiet: assert property (p_stop_quiet) else $error("target drove after stop");
  a_stable_high: assert property (p_stable_high) else $error("data moved with clock high");
  a_lag: assert property (p_lag) else $error("data change off the clock fall");
  a_scl_rate: assert property (p_scl_rate) else $error("clock period too short");
endmodule

/* File: tb/serial_eeprom_read_logic_bench.sv */
// Self-checking bench: controller and target joined by the link.
// Array model answers the target's address combinationally.
`timescale 1ns/10ps
module serial_eeprom_read_logic_bench;
  import sre_pkg::*;
  localparam logic [2:0] SEL = 3'h5;
  logic        clk_i;
  logic        rst_i;
  logic        cmd_valid;
  logic        cmd_ready;
  logic        rd_valid;
  logic        done;
  logic        nack;
  logic        wr_en;
  logic        read_active;
  logic [7:0]  wr_data;
  sre_cmd_e    cmd_kind;
  logic [12:0] cmd_addr;
  logic [12:0] mem_addr;
  logic [12:0] exp_ctr;
  logic [2:0]  cmd_sel;
  logic [7:0]  cmd_len;
  logic [7:0]  rd_data;
  logic [7:0]  mem_data;
  int          bad_count;
  int          comparisons;
  int          wr_seen;

  function automatic logic [7:0] mem_val(input logic [12:0] a);
    return a[7:0] ^ {3'h0, a[12:8]} ^ 8'h5a;
  endfunction

  sre_link_if link ();
  assign mem_data = mem_val(mem_addr);

  sre_target sre_target_i (.clk_i(clk_i), .rst_i(rst_i), .chip_select_bit2_i(SEL[2]),
    .chip_select_bit1_i(SEL[1]), .chip_select_bit0_i(SEL[0]), .mem_data_i(mem_data),
    .mem_addr_o(mem_addr), .wr_en_o(wr_en), .wr_data_o(wr_data),
    .read_active_o(read_active), .link(link));
  sre_controller sre_controller_i (.clk_i(clk_i), .rst_i(rst_i), .cmd_valid_i(cmd_valid),
    .cmd_kind_i(cmd_kind), .cmd_addr_i(cmd_addr), .cmd_sel_i(cmd_sel), .cmd_len_i(cmd_len),
    .cmd_ready_o(cmd_ready), .rd_valid_o(rd_valid), .rd_data_o(rd_data), .done_o(done),
    .nack_o(nack), .link(link));
  sre_link_monitor #(.SEL_VAL(SEL)) sre_link_monitor_i (.clk_i(clk_i), .rst_i(rst_i),
    .dev_sda_o(link.dev_sda_o), .dev_sda_oe(link.dev_sda_oe), .host_sda_o(link.host_sda_o),
    .host_sda_oe(link.host_sda_oe), .host_scl_o(link.host_scl_o),
    .host_scl_oe(link.host_scl_oe), .scl(link.scl), .sda(link.sda));

  always @(posedge clk_i) if (wr_en === 1'b1) wr_seen++;

  // ************************************************************
  // Shared tasks
  // ************************************************************
  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic print_verdict;
    $display("Counts: %0d mismatches, %0d comparisons", bad_count, comparisons);
    if (bad_count == 0 && comparisons > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  task automatic run_read(input sre_cmd_e kind, input logic [12:0] addr,
                          input logic [2:0] sel, input logic [7:0] len, input logic exp_nack);
    logic [12:0] first;
    logic [7:0]  cnt;
    logic        got_nack;
    int          n;
    int          i;
    int          act;
    first = (kind == SRE_CMD_RANDOM) ? addr : exp_ctr;
    cnt = (len == 8'h00) ? LEN_ONE : len;
    act = 0;
    got_nack = 1'b0;
    n = 0;
    @(posedge clk_i);
    #2;
    check("ready when idle", 1'b1, cmd_ready);
    cmd_kind = kind;
    cmd_addr = addr;
    cmd_sel = sel;
    cmd_len = len;
    cmd_valid = 1'b1;
    @(posedge clk_i);
    #2;
    cmd_valid = 1'b0;
    for (i = 0; i < 9000; i++) begin
      @(posedge clk_i);
      #2;
      if (rd_valid === 1'b1) begin
        check("read byte", mem_val(first + 13'(n)), rd_data);
        n++;
      end
      if (nack === 1'b1) got_nack = 1'b1;
      if (read_active === 1'b1) act++;
      if (done === 1'b1) break;
    end
    if (i == 9000) begin
      bad_count++;
      $display("ERROR done expected 1 seen timeout");
      print_verdict;
    end
    check("byte count", exp_nack ? 16'h0000 : {8'h00, cnt}, 16'(n));
    check("address nack", exp_nack, got_nack);
    check("read active seen", !exp_nack, act != 0);
    check("read active idle", 16'h0000, {15'h0000, read_active});
    if (!exp_nack) exp_ctr = first + {5'h00, cnt};
    check("counter", exp_ctr, mem_addr);
  endtask

  // ************************************************************
  // Scenarios
  // ************************************************************
  task automatic test_after_reset;
    run_read(SRE_CMD_CURRENT, 13'h0000, SEL, 8'h02, 1'b0);
  endtask
  task automatic test_random;
    run_read(SRE_CMD_RANDOM, 13'h0123, SEL, 8'h01, 1'b0);
  endtask
  task automatic test_sequential;
    run_read(SRE_CMD_CURRENT, 13'h1555, SEL, 8'h05, 1'b0);
    run_read(SRE_CMD_CURRENT, 13'h0000, SEL, 8'h00, 1'b0);
  endtask
  task automatic test_wrap;
    run_read(SRE_CMD_RANDOM, 13'h1ffe, SEL, 8'h04, 1'b0);
  endtask
  task automatic test_bad_select;
    run_read(SRE_CMD_RANDOM, 13'h0040, ~SEL, 8'h01, 1'b1);
    run_read(SRE_CMD_CURRENT, 13'h0000, SEL, 8'h01, 1'b0);
  endtask

  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end

  initial begin
    rst_i = 1'b1;
    cmd_valid = 1'b0;
    cmd_kind = SRE_CMD_CURRENT;
    cmd_addr = 13'h0000;
    cmd_sel = SEL;
    cmd_len = 8'h01;
    exp_ctr = 13'h0000;
    bad_count = 0;
    comparisons = 0;
    wr_seen = 0;
    repeat (12) @(posedge clk_i);
    #2;
    rst_i = 1'b0;
    repeat (4) @(posedge clk_i);
    test_after_reset;
    test_random;
    test_sequential;
    test_wrap;
    test_bad_select;
    check("write strobes", 16'h0000, 16'(wr_seen));
    check("write data", 16'h0000, {8'h00, wr_data});
    print_verdict;
  end
endmodule
